// *** rsd_top.v ***
// remote sensor decoder: current demodulator, manchester frame decoder,
// wheel speed decoder, result registers behind an axi4-lite slave.
// assumes current samples and slot strobes come from logic on i_ref_clk.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "rsd_defines.vh"
module rsd_top #(
  parameter P_VDA_BIT_CYC = `RSD_VDA_BIT_US * `RSD_CLK_MHZ
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_arst_n,
  // axi4-lite slave
  input wire [7:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  output wire o_s_axi_awready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  input wire i_s_axi_wvalid,
  output wire o_s_axi_wready,
  output reg [1:0] o_s_axi_bresp,
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [7:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  output wire o_s_axi_arready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  // sensor side
  input wire [9:0] i_sense_cur,
  input wire i_sense_vld,
  input wire i_slot_start,
  input wire [1:0] i_slot_idx,
  input wire [1:0] i_diag_fault,
  // pulse pin
  output reg o_wheel_pulse_out
);
  localparam S_IDLE = 2'b01;
  localparam S_RUN = 2'b10;
  localparam integer BIT_S_N = `RSD_BIT_SLOW_CYC;
  localparam integer BIT_F_N = `RSD_BIT_FAST_CYC;
  localparam integer DSTEP_N = `RSD_DGL_STEP_CYC;
  localparam integer PTICK_N = `RSD_PWM_TICK_CYC;
  localparam integer VBIT_N = P_VDA_BIT_CYC;
  localparam [11:0] BIT_S = BIT_S_N[11:0];
  localparam [11:0] BIT_F = BIT_F_N[11:0];
  localparam [15:0] DSTEP = DSTEP_N[15:0];
  localparam [9:0] PTICK = PTICK_N[9:0];
  localparam [15:0] VBIT = VBIT_N[15:0];

  function [2:0] crc3;
    input [16:0] d;
    reg [2:0] s;
    begin
      s = `RSD_CRC_SEED;
      crc3[2] = s[0]^d[0]^d[1]^d[3]^d[6]^d[7]^d[8]^d[10]^d[13]^d[14]^d[15];
      crc3[1] = s[2]^d[0]^d[1]^d[2]^d[4]^d[7]^d[8]^d[9]^d[11]^d[14]^d[15]^d[16];
      crc3[0] = s[1]^s[0]^d[0]^d[2]^d[5]^d[6]^d[7]^d[9]^d[12]^d[13]^d[14]^d[16];
    end
  endfunction

  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] stb;
    integer k;
    begin
      wmerge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (stb[k]) begin
          wmerge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  reg [31:0] setup_r;
  reg [31:0] trip_r;
  reg [3:0] tag_r;
  wire wheel = setup_r[`RSD_F_WHEEL];
  wire [1:0] variant = setup_r[`RSD_F_VAR_HI:`RSD_F_VAR_LO];
  wire [3:0] dgl = setup_r[`RSD_F_DGL_HI:`RSD_F_DGL_LO];

  // diagnostic fault inputs are analogue, so synchronise
  reg [1:0] dg_s1_r;
  reg [1:0] dg_s2_r;
  reg [1:0] diag_r;

  // current tracking and demodulation
  reg [9:0] base_r;
  reg [9:0] d1_r;
  reg [9:0] d2_r;
  reg demod_r;
  reg lvl2_r;
  wire [10:0] trip1 = {1'b0, base_r} + (setup_r[`RSD_F_CTRIP] ? {1'b0, trip_r[9:0]}
    : {2'b00, d1_r[9:1]});
  wire [10:0] trip2 = {1'b0, base_r} + (setup_r[`RSD_F_CTRIP] ? {1'b0, trip_r[25:16]}
    : ({1'b0, d1_r} + {2'b00, d2_r[9:1]}));
  wire signed [11:0] dev = $signed({2'b00, i_sense_cur}) - $signed({2'b00, base_r});
  wire signed [11:0] dev2 = dev - $signed({2'b00, d1_r});
  wire signed [11:0] bstep = dev >>> 4;
  wire signed [11:0] b_nxt = $signed({2'b00, base_r}) + bstep;
  wire signed [11:0] d1_nxt = $signed({2'b00, d1_r}) + ((dev - $signed({2'b00, d1_r})) >>> 4);
  wire signed [11:0] d2_nxt = $signed({2'b00, d2_r}) + ((dev2 - $signed({2'b00, d2_r})) >>> 4);

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      base_r <= `RSD_BASE_RST;
      d1_r <= `RSD_D1_RST;
      d2_r <= `RSD_D2_RST;
      demod_r <= 1'b0;
      lvl2_r <= 1'b0;
    end else if (i_sense_vld) begin
      demod_r <= ({1'b0, i_sense_cur} > trip1);
      lvl2_r <= ({1'b0, i_sense_cur} > trip2);
      if ({1'b0, i_sense_cur} <= trip1) begin
        if (b_nxt < $signed({2'b00, `RSD_BASE_MIN})) begin
          base_r <= `RSD_BASE_MIN;
        end else if (b_nxt > $signed({2'b00, `RSD_BASE_MAX})) begin
          base_r <= `RSD_BASE_MAX;
        end else begin
          base_r <= b_nxt[9:0];
        end
      end else if ({1'b0, i_sense_cur} <= trip2 || !wheel) begin
        if (d1_nxt > 0) begin
          d1_r <= d1_nxt[9:0];
        end
      end else if (d2_nxt > 0) begin
        d2_r <= d2_nxt[9:0];
      end
    end
  end

  // glitch filter: quarter bit in psi5 mode, deglitch setting in wheel mode
  reg flt_r;
  reg flt_d_r;
  reg [15:0] fcnt_r;
  wire [11:0] bit_min = setup_r[`RSD_F_FAST] ? BIT_F : BIT_S;
  wire [3:0] dsel = (dgl == 4'hf) ? 4'he : dgl;
  wire [15:0] flim = wheel ? (DSTEP * ({12'h000, dsel} + 16'h0001))
    : {6'h00, bit_min[11:2]};
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flt_r <= 1'b0;
      flt_d_r <= 1'b0;
      fcnt_r <= 16'h0000;
    end else begin
      flt_d_r <= flt_r;
      if (demod_r == flt_r) begin
        fcnt_r <= 16'h0000;
      end else if (fcnt_r + 16'h0001 >= flim) begin
        flt_r <= demod_r;
        fcnt_r <= 16'h0000;
      end else begin
        fcnt_r <= fcnt_r + 16'h0001;
      end
    end
  end
  wire edge_any = flt_r ^ flt_d_r;
  wire edge_fall = flt_d_r & ~flt_r;

  // manchester decoder
  reg [1:0] st_r;
  reg [11:0] tmr_r;
  reg [3:0] nb_r;
  reg bnd_r;
  reg [12:0] sh_r;
  reg [1:0] slot_r;
  reg m_ok;
  reg m_err;
  wire [11:0] wlo = bit_min - {2'b00, bit_min[11:2]};
  wire [11:0] whi = bit_min + {2'b00, bit_min[11:2]};
  // 8-bit frames carry two data bits fewer
  wire [3:0] nb_end = variant[0] ? `RSD_NBITS8 : `RSD_NBITS;
  wire bitv = ~flt_r;
  wire sb_bad = (nb_r < 4'h2) && bitv && !setup_r[`RSD_F_SBOFF];
  always @* begin
    m_ok = 1'b0;
    m_err = 1'b0;
    if (!wheel && st_r == S_RUN) begin
      if (i_slot_start) begin
        m_err = 1'b1;
      end else if (edge_any && tmr_r >= wlo) begin
        m_err = (nb_r == nb_end) || sb_bad;
      end else if (edge_any) begin
        m_err = bnd_r;
      end else if (tmr_r > whi) begin
        m_ok = (nb_r == nb_end);
        m_err = (nb_r != nb_end);
      end
    end
  end
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= S_IDLE;
      tmr_r <= 12'h000;
      nb_r <= 4'h0;
      bnd_r <= 1'b0;
      sh_r <= 13'h0000;
      slot_r <= 2'b00;
    end else begin
      if (i_slot_start) begin
        slot_r <= i_slot_idx;
      end
      case (st_r)
        S_IDLE: begin
          tmr_r <= 12'h000;
          bnd_r <= 1'b0;
          nb_r <= 4'h1;
          if (!wheel && !i_slot_start && edge_any && flt_r) begin
            st_r <= S_RUN;
          end
        end
        S_RUN: begin
          if (m_err || m_ok || wheel) begin
            st_r <= S_IDLE;
          end else if (edge_any && tmr_r >= wlo) begin
            nb_r <= nb_r + 4'h1;
            sh_r <= {bitv, sh_r[12:1]};
            tmr_r <= 12'h000;
            bnd_r <= 1'b0;
          end else begin
            if (edge_any) begin
              bnd_r <= 1'b1;
            end
            tmr_r <= tmr_r + 12'h001;
          end
        end
        default: begin
          st_r <= S_IDLE;
        end
      endcase
    end
  end
  wire [9:0] pdata = variant[0] ? {2'b00, sh_r[9:2]} : sh_r[9:0];
  wire [16:0] dword = {3'b000, tag_r, pdata};
  wire [31:0] psi_word = {12'h000, crc3(dword), dword};

  // wheel speed decoding
  reg [8:0] pw_r;
  reg [9:0] tick_r;
  reg pw_run_r;
  reg ss_prev_r;
  reg mask_r;
  reg [15:0] vt_r;
  reg [3:0] vcnt_r;
  reg [8:0] vsh_r;
  reg vact_r;
  reg lvl2_d_r;
  reg w_wr;
  reg [31:0] w_word;
  wire is_pwm = (variant == `RSD_WT_PWM2) || (variant == `RSD_WT_PWM1);
  wire pw_ss = (pw_r >= `RSD_SS_LO) && (pw_r <= `RSD_SS_HI);
  wire pw_ovf = pw_run_r && (pw_r == `RSD_PWM_OVF);
  wire v_start = lvl2_r && !lvl2_d_r;
  wire v_full = (vcnt_r == 4'h9);
  always @* begin
    w_wr = 1'b0;
    w_word = 32'h0000_0000;
    if (wheel && is_pwm && pw_run_r && (edge_fall || pw_ovf)) begin
      w_wr = 1'b1;
      w_word[8:0] = pw_r;
      w_word[`RSD_R_SS] = edge_fall && pw_ss;
    end else if (wheel && variant == `RSD_WT_3LVL && vact_r && (v_start || v_full)) begin
      w_wr = 1'b1;
      w_word[11:0] = {(v_full ? 4'h8 : vcnt_r), vsh_r[7:0]};
      if (v_full && ^vsh_r) begin
        w_word[`RSD_R_FLT] = 1'b1;
        w_word[30:28] = `RSD_E_INVAL;
      end
    end
  end
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pw_r <= 9'h000;
      tick_r <= 10'h000;
      pw_run_r <= 1'b0;
      ss_prev_r <= 1'b0;
      mask_r <= 1'b0;
      vt_r <= 16'h0000;
      vcnt_r <= 4'h0;
      vsh_r <= 9'h000;
      vact_r <= 1'b0;
      lvl2_d_r <= 1'b0;
    end else begin
      lvl2_d_r <= lvl2_r;
      if (edge_any && flt_r) begin
        pw_run_r <= 1'b1;
        pw_r <= 9'h000;
        tick_r <= 10'h000;
        mask_r <= ss_prev_r && setup_r[`RSD_F_SSFWD];
      end else if (w_wr && is_pwm) begin
        pw_run_r <= 1'b0;
        ss_prev_r <= w_word[`RSD_R_SS];
      end else if (pw_run_r) begin
        if (tick_r + 10'h001 >= PTICK) begin
          tick_r <= 10'h000;
          pw_r <= pw_r + 9'h001;
        end else begin
          tick_r <= tick_r + 10'h001;
        end
      end
      if (!flt_r && !pw_run_r && !ss_prev_r) begin
        mask_r <= 1'b0;
      end
      if (v_start) begin
        vact_r <= 1'b1;
        vcnt_r <= 4'h0;
        vt_r <= 16'h0000;
      end else if (v_full) begin
        vact_r <= 1'b0;
        vcnt_r <= 4'h0;
      end else if (vact_r) begin
        if (vt_r + 16'h0001 >= VBIT) begin
          vt_r <= 16'h0000;
          vsh_r <= {flt_r, vsh_r[8:1]};
          vcnt_r <= vcnt_r + 4'h1;
        end else begin
          vt_r <= vt_r + 16'h0001;
        end
      end
    end
  end

  // pulse pin
  wire two_lvl = (variant != `RSD_WT_3LVL);
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wheel_pulse_out <= 1'b0;
    end else if (setup_r[`RSD_F_TEST]) begin
      o_wheel_pulse_out <= setup_r[`RSD_F_TLVL];
    end else if (!wheel) begin
      o_wheel_pulse_out <= setup_r[`RSD_F_RAWFWD] && demod_r;
    end else if (two_lvl && setup_r[`RSD_F_WRAWFWD]) begin
      o_wheel_pulse_out <= demod_r;
    end else if (variant == `RSD_WT_3LVL) begin
      o_wheel_pulse_out <= lvl2_r;
    end else begin
      o_wheel_pulse_out <= flt_r && !mask_r;
    end
  end

  // result registers
  reg [31:0] res_r [0:2];
  reg [2:0] vld_r;
  reg wr_en;
  reg [1:0] wr_idx;
  reg [31:0] wr_val;
  always @* begin
    wr_en = 1'b0;
    wr_idx = 2'b00;
    wr_val = psi_word;
    if (!wheel && (m_ok || m_err)) begin
      wr_en = (slot_r != 2'b11);
      wr_idx = slot_r;
      if (m_err) begin
        wr_val = {1'b1, `RSD_E_MAN, 28'h000_0000};
      end
    end else if (wheel && w_wr) begin
      wr_en = 1'b1;
      wr_val = w_word;
    end
  end

  // axi4-lite slave
  reg aw_ok_r;
  reg w_ok_r;
  reg [7:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  assign o_s_axi_awready = !aw_ok_r && !o_s_axi_bvalid;
  assign o_s_axi_wready = !w_ok_r && !o_s_axi_bvalid;
  assign o_s_axi_arready = !o_s_axi_rvalid;
  wire do_wr = aw_ok_r && w_ok_r && !o_s_axi_bvalid;
  wire do_rd = i_s_axi_arvalid && o_s_axi_arready;
  wire [7:0] ra = i_s_axi_araddr;
  wire rd_res = do_rd && (ra == `RSD_A_RES0 || ra == `RSD_A_RES1 || ra == `RSD_A_RES2);
  wire [1:0] ridx = (ra == `RSD_A_RES0) ? 2'd0 : (ra == `RSD_A_RES1) ? 2'd1 : 2'd2;
  reg [31:0] rd_val;
  reg rd_bad;
  always @* begin
    rd_bad = 1'b0;
    rd_val = 32'h0000_0000;
    case (ra)
      `RSD_A_SETUP: rd_val = setup_r;
      `RSD_A_TRIP: rd_val = trip_r;
      `RSD_A_TAG: rd_val = {28'h000_0000, tag_r};
      `RSD_A_STAT: rd_val = {2'b00, diag_r, 2'b00, d1_r, 6'h00, base_r};
      `RSD_A_RES0, `RSD_A_RES1, `RSD_A_RES2: begin
        if (diag_r != 2'b00) begin
          rd_val = {1'b1, `RSD_E_DIAG, 26'h000_0000, diag_r};
        end else if (wheel && variant == `RSD_WT_STD) begin
          rd_val = {1'b1, `RSD_E_NODATA, 28'h000_0000};
        end else if (vld_r[ridx]) begin
          rd_val = res_r[ridx];
        end else begin
          rd_val = {1'b1, `RSD_E_EMPTY, 28'h000_0000};
        end
      end
      default: rd_bad = 1'b1;
    endcase
  end
  wire wbad = !(awaddr_r == `RSD_A_SETUP || awaddr_r == `RSD_A_TRIP ||
    awaddr_r == `RSD_A_TAG || awaddr_r == `RSD_A_STAT || awaddr_r == `RSD_A_RES0 ||
    awaddr_r == `RSD_A_RES1 || awaddr_r == `RSD_A_RES2);
  integer i;
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= 2'b00;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rresp <= 2'b00;
      o_s_axi_rdata <= 32'h0000_0000;
      setup_r <= `RSD_SETUP_RST;
      trip_r <= {6'h00, `RSD_FIX2_RST, 6'h00, `RSD_FIX1_RST};
      tag_r <= 4'h0;
      vld_r <= 3'b000;
      dg_s1_r <= 2'b00;
      dg_s2_r <= 2'b00;
      diag_r <= 2'b00;
      for (i = 0; i < 3; i = i + 1) begin
        res_r[i] <= 32'h0000_0000;
      end
    end else begin
      dg_s1_r <= i_diag_fault;
      dg_s2_r <= dg_s1_r;
      diag_r <= (rd_res ? 2'b00 : diag_r) | dg_s2_r;
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_ok_r <= 1'b1;
        awaddr_r <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_ok_r <= 1'b1;
        wdata_r <= i_s_axi_wdata;
        wstrb_r <= i_s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wbad ? 2'b10 : 2'b00;
        case (awaddr_r)
          `RSD_A_SETUP: setup_r <= wmerge(setup_r, wdata_r, wstrb_r);
          `RSD_A_TRIP: trip_r <= wmerge(trip_r, wdata_r, wstrb_r);
          `RSD_A_TAG: if (wstrb_r[0]) tag_r <= wdata_r[3:0];
          default: tag_r <= tag_r;
        endcase
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
      if (do_rd) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_val;
        o_s_axi_rresp <= rd_bad ? 2'b10 : 2'b00;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
      // new data wins over a clearing read in the same cycle
      for (i = 0; i < 3; i = i + 1) begin
        if (wr_en && wr_idx == i[1:0]) begin
          res_r[i] <= wr_val;
          vld_r[i] <= 1'b1;
        end else if (rd_res && ridx == i[1:0]) begin
          res_r[i] <= 32'h0000_0000;
          vld_r[i] <= 1'b0;
        end
      end
    end
  end
endmodule

// *** rsd_defines.vh ***
// named constants for the remote sensor decoder
// assumes a 125 MHz clock and a 10-bit current sample, 1 lsb = 0.05 mA
`ifndef RSD_DEFINES_VH
`define RSD_DEFINES_VH
// register byte addresses
`define RSD_A_SETUP 8'h00
`define RSD_A_TRIP 8'h04
`define RSD_A_TAG 8'h08
`define RSD_A_STAT 8'h0c
`define RSD_A_RES0 8'h10
`define RSD_A_RES1 8'h14
`define RSD_A_RES2 8'h18
// setup fields
`define RSD_F_WHEEL 0
`define RSD_F_VAR_LO 1
`define RSD_F_VAR_HI 2
`define RSD_F_CTRIP 3
`define RSD_F_RAWFWD 4
`define RSD_F_WRAWFWD 5
`define RSD_F_SSFWD 6
`define RSD_F_DGL_LO 7
`define RSD_F_DGL_HI 10
`define RSD_F_TEST 11
`define RSD_F_TLVL 12
`define RSD_F_FAST 13
`define RSD_F_SBOFF 14
`define RSD_SETUP_RST 32'h0000_0000
// wheel sensor types
`define RSD_WT_STD 2'h0
`define RSD_WT_3LVL 2'h1
`define RSD_WT_PWM2 2'h2
`define RSD_WT_PWM1 2'h3
// result fields and fault codes
`define RSD_R_FLT 31
`define RSD_R_TAG_LO 10
`define RSD_R_CRC_LO 17
`define RSD_R_SS 15
`define RSD_E_MAN 3'h1
`define RSD_E_INVAL 3'h2
`define RSD_E_NODATA 3'h3
`define RSD_E_EMPTY 3'h4
`define RSD_E_DIAG 3'h5
`define RSD_CRC_SEED 3'h7
// tracking, codes at 0.05 mA
`define RSD_BASE_RST 10'h08c
`define RSD_BASE_MIN 10'h032
`define RSD_BASE_MAX 10'h1a4
`define RSD_D1_RST 10'h08c
`define RSD_D2_RST 10'h118
`define RSD_FIX1_RST 10'h038
`define RSD_FIX2_RST 10'h0fc
// timing
`define RSD_CLK_MHZ 125
`define RSD_BIT_SLOW_NS 8000
`define RSD_BIT_FAST_NS 5291
`define RSD_BIT_SLOW_CYC (`RSD_BIT_SLOW_NS * `RSD_CLK_MHZ / 1000)
`define RSD_BIT_FAST_CYC (`RSD_BIT_FAST_NS * `RSD_CLK_MHZ / 1000)
`define RSD_DGL_STEP_NS 64
`define RSD_DGL_STEP_CYC (`RSD_DGL_STEP_NS * `RSD_CLK_MHZ / 1000)
`define RSD_PWM_TICK_NS 5000
`define RSD_PWM_TICK_CYC (`RSD_PWM_TICK_NS * `RSD_CLK_MHZ / 1000)
`define RSD_VDA_BIT_US 50
`define RSD_PWM_OVF 9'h1ff
`define RSD_SS_LO 9'h0a0
`define RSD_SS_HI 9'h140
`define RSD_NBITS 4'hf
`define RSD_NBITS8 4'hd
`endif

// *** rsd_top_chk.sv ***
// axi4-lite slave assertions for the remote sensor decoder
// bound to rsd_top from the testbench top; one clock domain
`timescale 1ns/1ps
module rsd_top_chk (
  // clock and reset
  input wire i_ref_clk,
  input wire i_arst_n,
  // axi4-lite
  input wire [7:0] i_s_axi_awaddr,
  input wire i_s_axi_awvalid,
  input wire o_s_axi_awready,
  input wire i_s_axi_wvalid,
  input wire o_s_axi_wready,
  input wire [1:0] o_s_axi_bresp,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire [7:0] i_s_axi_araddr,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire [31:0] o_s_axi_rdata,
  input wire [1:0] o_s_axi_rresp,
  input wire o_s_axi_rvalid,
  input wire i_s_axi_rready
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  wire wr_hs = i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  wire ar_hs = i_s_axi_arvalid && o_s_axi_arready;
  wire aw_bad = i_s_axi_awaddr > 8'h18 || i_s_axi_awaddr[1:0] != 2'h0;
  wire ar_bad = i_s_axi_araddr > 8'h18 || i_s_axi_araddr[1:0] != 2'h0;
  a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
    o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write response dropped early");
  a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata) && $stable(o_s_axi_rresp))
    else $error("read data changed while pending");
  a_read_next: assert property (ar_hs |=> o_s_axi_rvalid) else $error("read answer late");
  a_read_once: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
    else $error("read answer repeated");
  a_ar_blocked: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while answer pending");
  a_aw_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while response pending");
  a_wr_bad_resp: assert property (wr_hs && aw_bad |-> ##[1:2]
    (o_s_axi_bvalid && o_s_axi_bresp == 2'b10)) else $error("unmapped write not refused");
  a_wr_ok_resp: assert property (wr_hs && !aw_bad |-> ##[1:2]
    (o_s_axi_bvalid && o_s_axi_bresp == 2'b00)) else $error("mapped write refused");
  a_rd_bad_resp: assert property (ar_hs && ar_bad |=>
    o_s_axi_rresp == 2'b10 && o_s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule

// *** rsd_sensor_model.sv ***
// current-mode sensor sending manchester frames lsb first, logic 0 rises mid-bit
// runs on the decoder clock; a sample is valid every cycle out of reset
`timescale 1ns/1ps
module rsd_sensor_model #(
  parameter P_BIT = 1000,
  parameter [9:0] P_LO = 10'h08c,
  parameter [9:0] P_HI = 10'h1a4
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_arst_n,
  // frame request
  input wire i_go,
  input wire [14:0] i_word,
  input wire [3:0] i_nbits,
  output wire o_busy,
  // sensor current
  output wire [9:0] o_cur,
  output reg o_vld
);
  reg [14:0] word_r;
  reg [3:0] left_r;
  integer ph_r;
  wire hi = word_r[0] ? (ph_r < P_BIT / 2) : (ph_r >= P_BIT / 2);
  assign o_busy = left_r != 4'h0;
  // quiescent level outside frames
  assign o_cur = (o_busy && hi) ? P_HI : P_LO;
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      word_r <= 15'h0;
      left_r <= 4'h0;
      ph_r <= 0;
      o_vld <= 1'b0;
    end else begin
      o_vld <= 1'b1;
      if (i_go) begin
        word_r <= i_word;
        left_r <= i_nbits;
        ph_r <= 0;
      end else if (o_busy && ph_r == P_BIT - 1) begin
        ph_r <= 0;
        word_r <= word_r >> 1;
        left_r <= left_r - 4'h1;
      end else if (o_busy) begin
        ph_r <= ph_r + 1;
      end
    end
  end
endmodule

// *** rsd_top_tb.sv ***
// self-checking bench: axi4-lite master, sensor model, read result queue
// one 125 MHz clock, reset held 10 cycles
`timescale 1ns/1ps
`include "rsd_defines.vh"
`define CHK(g, x) begin check_count++; if ((g) !== (x)) begin mismatches++; \
  $display("mismatch at %0t got %h exp %h", $time, g, x); end end
module rsd_top_tb;
  reg clk = 0;
  reg rst_n = 0;
  reg [7:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, seed = 59;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, go = 0, sst = 0;
  reg [1:0] sidx = 0, diag = 0;
  reg [14:0] word = 0;
  reg [3:0] nbits = 0, tag = 0;
  reg [9:0] d = 0;
  reg [65:0] e;
  reg [65:0] expq[$];
  wire awready, wready, bvalid, arready, rvalid, busy, vld, pulse;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [9:0] cur;
  integer mismatches = 0, check_count = 0, t;
  initial begin
    forever #4 clk = ~clk;
  end
  rsd_top #(.P_VDA_BIT_CYC(20)) rsd_top_inst (.i_ref_clk(clk), .i_arst_n(rst_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_sense_cur(cur), .i_sense_vld(vld),
    .i_slot_start(sst), .i_slot_idx(sidx), .i_diag_fault(diag), .o_wheel_pulse_out(pulse));
  rsd_sensor_model rsd_sensor_model_inst (.i_ref_clk(clk), .i_arst_n(rst_n), .i_go(go),
    .i_word(word), .i_nbits(nbits), .o_busy(busy), .o_cur(cur), .o_vld(vld));
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  function [31:0] good(input [3:0] g, input [9:0] v);
    reg [16:0] q;
    reg [2:0] c;
    q = {3'h0, g, v};
    c[2] = 1'b1 ^ q[0] ^ q[1] ^ q[3] ^ q[6] ^ q[7] ^ q[8] ^ q[10] ^ q[13] ^ q[14] ^ q[15];
    c[1] = 1'b1 ^ q[0] ^ q[1] ^ q[2] ^ q[4] ^ q[7] ^ q[8] ^ q[9] ^ q[11] ^ q[14] ^ q[15] ^ q[16];
    c[0] = q[0] ^ q[2] ^ q[5] ^ q[6] ^ q[7] ^ q[9] ^ q[12] ^ q[13] ^ q[14] ^ q[16];
    good = {12'h0, c, q};
  endfunction
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task hang;
    begin
      mismatches++;
      final_report;
    end
  endtask
  // result queue checked when a read answer is taken
  always @(posedge clk) begin
    if (rvalid && rready) begin
      e = expq.pop_front();
      `CHK({rresp, rdata & e[63:32]}, {e[65:64], e[31:0]})
    end
  end
  task wr(input [7:0] a, input [31:0] v, input [1:0] er);
    integer n;
    reg ta, tw, hb;
    reg [1:0] rb;
    begin
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(negedge clk);
        ta = awvalid && awready;
        tw = wvalid && wready;
        hb = bvalid;
        rb = bresp;
        @(posedge clk);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
        n++;
      end while (!hb && n < 50);
      if (!hb) hang;
      bready <= 1'b0;
      `CHK(rb, er)
    end
  endtask
  task rd(input [7:0] a, input [31:0] x, input [31:0] m, input [1:0] er);
    integer n;
    reg ta, hb;
    begin
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(negedge clk);
        ta = arvalid && arready;
        hb = rvalid;
        @(posedge clk);
        if (ta) arvalid <= 1'b0;
        if (ta) expq.push_back({er, m, x});
        n++;
      end while (!hb && n < 50);
      if (!hb) hang;
      rready <= 1'b0;
    end
  endtask
  // one slot, one frame; notes whether the pulse pin went high while the sensor model was busy
  task frame(input [1:0] s, input [9:0] v, input [3:0] nb, input xp);
    integer n;
    reg seen;
    begin
      n = 0;
      seen = 1'b0;
      @(posedge clk);
      sst <= 1'b1;
      sidx <= s;
      @(posedge clk);
      sst <= 1'b0;
      go <= 1'b1;
      word <= {3'h5, v, 2'h0};
      nbits <= nb;
      @(posedge clk);
      go <= 1'b0;
      do begin
        @(negedge clk);
        seen = seen | pulse;
        n++;
      end while (busy && n < 20000);
      if (busy) hang;
      repeat (3000) @(posedge clk);
      `CHK(seen, xp)
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(`RSD_A_SETUP, `RSD_SETUP_RST, 32'hffff_ffff, 2'h0);
    rd(`RSD_A_TRIP, {6'h0, `RSD_FIX2_RST, 6'h0, `RSD_FIX1_RST}, 32'hffff_ffff, 2'h0);
    rd(8'h40, 32'h0, 32'hffff_ffff, 2'b10);
    wr(8'h40, seed, 2'b10);
    seed = xs(seed);
    tag = seed[3:0];
    wr(`RSD_A_TAG, seed, 2'h0);
    rd(`RSD_A_TAG, {28'h0, tag}, 32'hf, 2'h0);
    wr(`RSD_A_SETUP, 32'h18, 2'h0);
    seed = xs(seed);
    d = seed[9:0];
    frame(2'h0, d, 4'hf, 1'b1);
    rd(`RSD_A_RES0, good(tag, d), 32'hffff_ffff, 2'h0);
    rd(`RSD_A_RES0, {1'b1, `RSD_E_EMPTY, 28'h0}, 32'hf000_0000, 2'h0);
    wr(`RSD_A_SETUP, 32'h1a, 2'h0);
    frame(2'h0, d, 4'hd, 1'b1);
    rd(`RSD_A_RES0, good(tag, {2'h0, d[7:0]}), 32'hffff_ffff, 2'h0);
    wr(`RSD_A_SETUP, 32'h8, 2'h0);
    seed = xs(seed);
    d = seed[9:0];
    frame(2'h1, d, 4'ha, 1'b0);
    rd(`RSD_A_RES1, {1'b1, `RSD_E_MAN, 28'h0}, 32'hf000_0000, 2'h0);
    wr(`RSD_A_SETUP, 32'h0, 2'h0);
    frame(2'h2, d, 4'hf, 1'b0);
    rd(`RSD_A_RES2, good(tag, d), 32'hffff_ffff, 2'h0);
    for (t = 0; t < 4; t++) begin
      wr(`RSD_A_SETUP, {29'h0, t[1:0], 1'b1}, 2'h0);
      rd(`RSD_A_SETUP, {29'h0, t[1:0], 1'b1}, 32'hffff_ffff, 2'h0);
    end
    wr(`RSD_A_SETUP, 32'h1, 2'h0);
    rd(`RSD_A_RES0, {1'b1, `RSD_E_NODATA, 28'h0}, 32'hf000_0000, 2'h0);
    for (t = 0; t < 2; t++) begin
      wr(`RSD_A_SETUP, {19'h0, t[0], 12'h801}, 2'h0);
      repeat (4) @(posedge clk);
      `CHK(pulse, t[0])
    end
    diag <= 2'h1;
    repeat (5) @(posedge clk);
    diag <= 2'h0;
    repeat (5) @(posedge clk);
    rd(`RSD_A_STAT, 32'h1000_0000, 32'h3000_0000, 2'h0);
    rd(`RSD_A_STAT, 32'h1000_0000, 32'h3000_0000, 2'h0);
    rd(`RSD_A_RES0, {1'b1, `RSD_E_DIAG, 26'h0, 2'h1}, 32'hffff_ffff, 2'h0);
    rd(`RSD_A_STAT, 32'h0, 32'h3000_0000, 2'h0);
    final_report;
  end
endmodule
bind rsd_top rsd_top_chk rsd_top_chk_inst (.i_ref_clk, .i_arst_n, .i_s_axi_awaddr,
  .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
  .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
  .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready);
